// >>> bench/csr_core_regs_tb_top.sv
// self-checking bench for the core status, option and irq control register bank
`timescale 1ns/1ps
module csr_core_regs_tb_top;
    import csr_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, branch = 1'b0;
    logic        ext_irq_pin = 1'b0, timer_zero_ovf = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [7:0]  periph_flags = 8'h00, periph_enables = 8'h00, fsr_addr = 8'h00;
    logic [3:0]  port_b_upper_pins = 4'h0;
    csr_alu_s    alu = '0;
    csr_evt_s    evt = '0;
    logic        awready, wready, bvalid, arready, rvalid, pud, rising, tsrc, tfall, owner;
    logic        irq_req;
    logic [1:0]  bresp, rresp, direct_bank;
    logic [31:0] rdata;
    logic [8:0]  indirect_addr;
    logic [7:0]  tdiv, wdiv, st, d, a, b, w, r;
    logic [4:0]  pc_upper, h;
    logic [8:0]  s;
    csr_alu_e    o;
    int          mismatches = 0, n_compared = 0, seed = 12010;
    logic [3:0]  ev [6] = '{4'h1, 4'h4, 4'h2, 4'h8, 4'h4, 4'h2};
    logic [7:0]  pv [4] = '{8'h80, 8'hc0, 8'h40, 8'hc0};

    always #20 aclk = ~aclk;

    csr_core_regs DUT (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .alu(alu),
        .evt(evt), .branch(branch), .periph_flags(periph_flags),
        .periph_enables(periph_enables), .timer_zero_ovf(timer_zero_ovf),
        .ext_irq_pin(ext_irq_pin), .port_b_upper_pins(port_b_upper_pins),
        .fsr_addr(fsr_addr), .indirect_addr(indirect_addr), .direct_bank(direct_bank),
        .pullup_disable(pud), .ext_irq_rising(rising), .timer_src_pin(tsrc),
        .timer_falling(tfall), .prescaler_to_wdt(owner), .timer_div_log2(tdiv),
        .wdt_div_log2(wdiv), .pc_upper(pc_upper), .irq_req(irq_req));

    task automatic conclude;
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic hang;
        mismatches++;
        $display("unexpected at %0t: bus answer missing", $time);
        conclude();
    endtask : hang

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask : tick

    // upper data bits random: only the low byte may land
    task automatic wr(input logic [8:0] idx, input logic [7:0] v, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= {1'b0, idx, 2'b00};
        wdata <= {24'($random(seed)), v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 40) hang();
        else chk({30'h0, bresp}, {30'h0, er}, "bresp");
    endtask : wr

    task automatic rd(input logic [8:0] idx, input logic [7:0] v, input logic [1:0] er,
                      input string m);
        int n;
        @(posedge aclk);
        araddr <= {1'b0, idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (n == 40) begin
            hang();
        end else begin
            chk({30'h0, rresp}, {30'h0, er}, m);
            chk(rdata, {24'h0, v}, m);
        end
    endtask : rd

    // request model: peripheral enables count only through the peripheral enable bit
    function automatic logic ireq(input logic [7:0] c);
        return c[7] & ((|(c[5:3] & c[2:0])) | (c[6] & (|(periph_flags & periph_enables))));
    endfunction : ireq

    task automatic icheck(input logic [7:0] v, input string m);
        tick(4);
        rd(CSR_IDX_IRQCTL, v, AXI_OKAY, m);
        chk({31'h0, irq_req}, {31'h0, ireq(v)}, m);
    endtask : icheck

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        st = CSR_RST_STATUS;
        rd(CSR_IDX_STATUS, st, AXI_OKAY, "status reset");
        rd(CSR_IDX_OPTION, CSR_RST_OPTION, AXI_OKAY, "option reset");
        rd(CSR_IDX_IRQCTL, CSR_RST_IRQCTL, AXI_OKAY, "irq reset");
        foreach (ev[k]) begin
            evt <= ev[k];
            @(posedge aclk);
            evt <= '0;
            if (ev[k][3] | ev[k][0]) st[4:3] = 2'b11;
            if (ev[k][2]) st[4:3] = 2'b10;
            if (ev[k][1]) st[4] = 1'b0;
            rd(CSR_IDX_STATUS, st, AXI_OKAY, "reset cause");
        end
        // both cause flags now low, so writing ones must not raise them
        for (int k = 0; k < 8; k++) begin
            fsr_addr <= 8'($random(seed));
            wr({k[1:0], 7'h00} | CSR_IDX_STATUS, {k[2:0], 5'h1f}, AXI_OKAY);
            st = {k[2:0], st[4:3], 3'b111};
            rd({~k[1:0], 7'h00} | CSR_IDX_STATUS, st, AXI_OKAY, "status");
            chk({30'h0, direct_bank}, {30'h0, k[1:0]}, "direct bank");
            chk({23'h0, indirect_addr}, {23'h0, k[2], fsr_addr}, "indirect");
        end
        for (int k = 0; k < 30; k++) begin
            o = csr_alu_e'(k % 6);
            a = 8'($random(seed));
            b = 8'($random(seed));
            w = 8'($random(seed));
            if (k % 4 == 0) b = (o == CSR_OP_SUB) ? a : (o == CSR_OP_LOG) ? ~a : 8'(0 - a);
            h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
            case (o)
                CSR_OP_ADD: s = {1'b0, a} + {1'b0, b};
                CSR_OP_SUB: begin
                    s = {1'b0, a} + {1'b0, ~b} + 9'h001;
                    h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
                end
                CSR_OP_NONE: s = {st[0], a};
                CSR_OP_LOG: s = {st[0], a & b};
                CSR_OP_RRC: s = {a[0], st[0], a[7:1]};
                default:    s = {a[7], a[6:0], st[0]};
            endcase
            r = s[7:0];
            if (o == CSR_OP_ADD || o == CSR_OP_SUB) st[1] = h[4];
            if (o != CSR_OP_NONE && o <= CSR_OP_LOG) st[2] = (r == 8'h00);
            st[0] = s[8];
            st[7:5] = w[7:5];
            // a plain move into status keeps the written flags
            if (o == CSR_OP_NONE) st[2:0] = w[2:0];
            alu <= '{o, a, b, r, 1'b1, w};
            @(posedge aclk);
            alu <= '0;
            rd(CSR_IDX_STATUS, st, AXI_OKAY, "alu flags");
        end
        for (int k = 0; k < 8; k++) begin
            d = {5'($random(seed)), k[2:0]};
            wr((k % 2 == 1) ? 9'h181 : CSR_IDX_OPTION, d, AXI_OKAY);
            rd(CSR_IDX_OPTION, d, AXI_OKAY, "option");
            chk({27'h0, pud, rising, tsrc, tfall, owner}, {27'h0, d[7:3]}, "cfg");
            chk({16'h0, tdiv, wdiv}, d[3] ? {24'h0, 5'h0, d[2:0]}
                : {16'h0, 8'(d[2:0]) + 8'h01, 8'h00}, "ratio");
        end
        rd(CSR_IDX_PORT_B, 8'h00, AXI_OKAY, "port");
        wr(CSR_IDX_IRQCTL, 8'h00, AXI_OKAY);
        timer_zero_ovf <= 1'b1;
        @(posedge aclk);
        timer_zero_ovf <= 1'b0;
        icheck(8'h04, "tmr flag");
        wr(CSR_IDX_IRQCTL, 8'ha4, AXI_OKAY);
        icheck(8'ha4, "tmr irq");
        wr(CSR_IDX_IRQCTL, 8'h80, AXI_OKAY);
        icheck(8'h80, "tmr clear");
        // overflow while frozen must not land
        clk_en <= 1'b0;
        timer_zero_ovf <= 1'b1;
        tick(2);
        clk_en <= 1'b1;
        timer_zero_ovf <= 1'b0;
        icheck(8'h80, "frozen");
        for (int k = 0; k < 2; k++) begin
            wr(CSR_IDX_OPTION, {1'b0, k[0], 6'h00}, AXI_OKAY);
            for (int j = 0; j < 2; j++) begin
                wr(CSR_IDX_IRQCTL, 8'h90, AXI_OKAY);
                ext_irq_pin <= ~ext_irq_pin;
                icheck({6'h24, 1'(k ^ j), 1'b0}, "ext edge");
            end
        end
        periph_flags <= 8'h01;
        for (int k = 0; k < 4; k++) begin
            periph_enables <= {7'h00, k < 3};
            wr(CSR_IDX_IRQCTL, pv[k], AXI_OKAY);
            icheck(pv[k], "periph");
        end
        // mismatch keeps re-setting the flag until the port is read
        port_b_upper_pins <= 4'h5;
        wr(CSR_IDX_IRQCTL, 8'h88, AXI_OKAY);
        icheck(8'h89, "port set");
        wr(CSR_IDX_IRQCTL, 8'h88, AXI_OKAY);
        icheck(8'h89, "port held");
        rd(CSR_IDX_PORT_B, 8'h50, AXI_OKAY, "port read");
        wr(CSR_IDX_IRQCTL, 8'h88, AXI_OKAY);
        icheck(8'h88, "port clear");
        wr(CSR_IDX_PCLATCH, 8'h15, AXI_OKAY);
        branch <= 1'b1;
        @(posedge aclk);
        branch <= 1'b0;
        tick(3);
        chk({27'h0, pc_upper}, 32'h15, "pc upper");
        rd(9'h050, 8'h00, AXI_SLVERR, "unmapped");
        wr(9'h050, 8'h5a, AXI_SLVERR);
        wr(CSR_IDX_RESCTL, 8'h00, AXI_OKAY);
        conclude();
    end
endmodule : csr_core_regs_tb_top

// >>> hw/csr_core_regs.sv
// core status, option and irq control register bank with axi4-lite slave
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
// Overview of operation
// - flag-updating ops override written z, nc, c
// - watchdog and halt flags ignore software writes
// - indirect bank bit picks banks 2-3 or 0-1
// - two-bit field picks one of four banks
// - watchdog flag set on power/kick/halt, cleared timeout
// - halt flag set on power/kick, cleared halt
// - zero flag reflects all-zero result
// - nibble carry from bit 3, inverted on subtract
// - subtract by two's complement; rotates load carry
// - pull-up disable bit gates all port pull-ups
// - edge select picks rising or falling external edge
// - source select picks pin or instruction clock
// - timer edge select picks pin transition direction
// - owner bit gives prescaler to watchdog or timer
// - ratio field sets timer and watchdog division
// - global enable gates all interrupts
// - peripheral enable gates peripheral interrupts
// - flags set regardless of enables
// - timer overflow flag sticky until software clears
// - external pin flag sticky until software clears
// - port change flag held while mismatch remains
// - pc latch feeds upper pc on branch
// - status and irq control mirrored in all banks
// - peripheral enables need peripheral enable bit
module csr_core_regs
    import csr_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire csr_alu_s    alu,
    input  wire csr_evt_s    evt,
    input  wire logic        branch,
    input  wire logic [7:0]  periph_flags,
    input  wire logic [7:0]  periph_enables,
    input  wire logic        timer_zero_ovf,
    input  wire logic        ext_irq_pin,
    input  wire logic [3:0]  port_b_upper_pins,
    input  wire logic [7:0]  fsr_addr,
    output logic [8:0]       indirect_addr,
    output logic [1:0]       direct_bank,
    output logic             pullup_disable,
    output logic             ext_irq_rising,
    output logic             timer_src_pin,
    output logic             timer_falling,
    output logic             prescaler_to_wdt,
    output logic [7:0]       timer_div_log2,
    output logic [7:0]       wdt_div_log2,
    output logic [4:0]       pc_upper,
    output logic             irq_req
);
    logic [7:0] status_q, option_q, irqctl_q;
    logic [4:0] pclat_q;
    logic [1:0] ext_sync_q, ext_prev_q;
    logic [3:0] pb_s1_q, pb_s2_q, pb_last_q;
    logic       aw_hold_q, w_hold_q;
    logic [8:0] aw_idx_q;
    logic [7:0] w_byte_q;
    logic       w_en_q;
    logic [8:0] aw_idx_w, ar_idx;
    logic       wr_fire, rd_fire, wr_ok;
    logic [7:0] rd_val;
    logic       rd_ok;
    logic       ext_edge, pb_mismatch, pb_read;
    logic [8:0] sum9;
    logic [4:0] sum5;
    // accepts address and data in either order, answers after both
    assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q     <= 1'b0;
            w_hold_q      <= 1'b0;
            aw_idx_q      <= 9'h000;
            w_byte_q      <= 8'h00;
            w_en_q        <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= AXI_OKAY;
        end else if (clk_en) begin
            s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_idx_q  <= s_axi_awaddr[10:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                w_byte_q <= s_axi_wdata[7:0];
                w_en_q   <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_hold_q    <= 1'b0;
                w_hold_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? AXI_OKAY : AXI_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // mirrored decode drops the bank bits
    assign aw_idx_w = aw_idx_q;
    assign wr_ok = ({2'b00, aw_idx_w[6:0]} == CSR_IDX_STATUS)
        || ({2'b00, aw_idx_w[6:0]} == CSR_IDX_IRQCTL)
        || ({2'b00, aw_idx_w[6:0]} == CSR_IDX_PCLATCH)
        || (aw_idx_w == CSR_IDX_OPTION) || (aw_idx_w == (CSR_IDX_OPTION | 9'h100))
        || (aw_idx_w == CSR_IDX_RESCTL);

    function automatic logic is_reg(input logic [8:0] idx, input logic [8:0] base);
        is_reg = ({2'b00, idx[6:0]} == base);
    endfunction : is_reg

    // status register
    assign sum9 = (alu.op == CSR_OP_SUB) ? {1'b0, alu.a} + {1'b0, ~alu.b} + 9'h001
                                         : {1'b0, alu.a} + {1'b0, alu.b};
    assign sum5 = (alu.op == CSR_OP_SUB) ? {1'b0, alu.a[3:0]} + {1'b0, ~alu.b[3:0]} + 5'h01
                                         : {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= CSR_RST_STATUS;
        end else if (clk_en) begin
            if (wr_fire && w_en_q && is_reg(aw_idx_q, CSR_IDX_STATUS)) begin
                status_q[7:5] <= w_byte_q[7:5];
                status_q[2:0] <= w_byte_q[2:0];
            end
            if (alu.dest_status) begin
                status_q[7:5] <= alu.wdata[7:5];
                // flag-affecting ops keep all three flags out of the write
                if (alu.op == CSR_OP_NONE)
                    status_q[2:0] <= alu.wdata[2:0];
            end
            // flag updates override any write in the same cycle; rotates leave z alone
            if (alu.op == CSR_OP_ADD || alu.op == CSR_OP_SUB || alu.op == CSR_OP_LOG) begin
                status_q[CSR_ST_Z] <= (alu.res == 8'h00);
            end
            if (alu.op == CSR_OP_ADD || alu.op == CSR_OP_SUB) begin
                status_q[CSR_ST_NC] <= sum5[4];
                status_q[CSR_ST_C]  <= sum9[8];
            end else if (alu.op == CSR_OP_RRC) begin
                status_q[CSR_ST_C] <= alu.a[0];
            end else if (alu.op == CSR_OP_RLC) begin
                status_q[CSR_ST_C] <= alu.a[7];
            end
            if (evt.power_up || evt.wdt_kick) begin
                status_q[CSR_ST_WDX]  <= 1'b1;
                status_q[CSR_ST_HALT] <= 1'b1;
            end else if (evt.halt) begin
                status_q[CSR_ST_WDX]  <= 1'b1;
                status_q[CSR_ST_HALT] <= 1'b0;
            end else if (evt.wdt_timeout) begin
                status_q[CSR_ST_WDX] <= 1'b0;
            end
        end
    end

    // option and pc latch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            option_q <= CSR_RST_OPTION;
            pclat_q  <= CSR_RST_PCLAT;
            pc_upper <= CSR_RST_PCLAT;
        end else if (clk_en) begin
            if (wr_fire && w_en_q && aw_idx_q[6:0] == CSR_IDX_OPTION[6:0] && aw_idx_q[7])
                option_q <= w_byte_q;
            if (wr_fire && w_en_q && is_reg(aw_idx_q, CSR_IDX_PCLATCH))
                pclat_q <= w_byte_q[4:0];
            if (branch)
                pc_upper <= pclat_q;
        end
    end

    // pin synchronisers; first stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_sync_q <= 2'b00;
            ext_prev_q <= 2'b00;
            pb_s1_q    <= 4'h0;
            pb_s2_q    <= 4'h0;
            pb_last_q  <= 4'h0;
        end else if (clk_en) begin
            ext_sync_q <= {ext_sync_q[0], ext_irq_pin};
            ext_prev_q <= {ext_prev_q[0], ext_sync_q[1]};
            pb_s1_q    <= port_b_upper_pins;
            pb_s2_q    <= pb_s1_q;
            if (pb_read)
                pb_last_q <= pb_s2_q;
        end
    end
    assign ext_edge = option_q[CSR_OP_EDGE] ? (ext_prev_q[0] && !ext_prev_q[1])
                                            : (!ext_prev_q[0] && ext_prev_q[1]);
    assign pb_mismatch = (pb_s2_q != pb_last_q);
    assign pb_read = rd_fire && is_reg(ar_idx, CSR_IDX_PORT_B);

    // irq control: hardware set wins over software clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irqctl_q <= CSR_RST_IRQCTL;
        end else if (clk_en) begin
            if (wr_fire && w_en_q && is_reg(aw_idx_q, CSR_IDX_IRQCTL))
                irqctl_q <= w_byte_q;
            if (timer_zero_ovf)
                irqctl_q[CSR_IC_TIF] <= 1'b1;
            if (ext_edge)
                irqctl_q[CSR_IC_EIF] <= 1'b1;
            if (pb_mismatch)
                irqctl_q[CSR_IC_PIF] <= 1'b1;
        end
    end

    // read side
    assign ar_idx  = s_axi_araddr[10:2];
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    always_comb begin
        rd_val = 8'h00;
        rd_ok  = 1'b1;
        if (is_reg(ar_idx, CSR_IDX_STATUS)) begin
            rd_val = status_q;
        end else if (is_reg(ar_idx, CSR_IDX_IRQCTL)) begin
            rd_val = irqctl_q;
        end else if (is_reg(ar_idx, CSR_IDX_PCLATCH)) begin
            rd_val = {3'h0, pclat_q};
        end else if (ar_idx[6:0] == CSR_IDX_OPTION[6:0] && ar_idx[7]) begin
            rd_val = option_q;
        end else if (is_reg(ar_idx, CSR_IDX_PORT_B)) begin
            rd_val = {pb_s2_q, 4'h0};
        end else begin
            rd_ok = 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= AXI_OKAY;
        end else if (clk_en) begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rd_val};
                s_axi_rresp  <= rd_ok ? AXI_OKAY : AXI_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // configuration outputs and request, all registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            indirect_addr    <= 9'h000;
            direct_bank      <= 2'b00;
            pullup_disable   <= CSR_RST_OPTION[CSR_OP_PUDIS];
            ext_irq_rising   <= CSR_RST_OPTION[CSR_OP_EDGE];
            timer_src_pin    <= CSR_RST_OPTION[CSR_OP_SRC];
            timer_falling    <= CSR_RST_OPTION[CSR_OP_TSE];
            prescaler_to_wdt <= CSR_RST_OPTION[CSR_OP_OWNER];
            // reset option gives the prescaler to the watchdog, timer runs undivided
            timer_div_log2   <= 8'h00;
            wdt_div_log2     <= {5'h00, CSR_RST_OPTION[2:0]};
            irq_req          <= 1'b0;
        end else if (clk_en) begin
            indirect_addr    <= {status_q[CSR_ST_IBANK], fsr_addr};
            direct_bank      <= status_q[CSR_ST_DB_HI:CSR_ST_DB_LO];
            pullup_disable   <= option_q[CSR_OP_PUDIS];
            ext_irq_rising   <= option_q[CSR_OP_EDGE];
            timer_src_pin    <= option_q[CSR_OP_SRC];
            timer_falling    <= option_q[CSR_OP_TSE];
            prescaler_to_wdt <= option_q[CSR_OP_OWNER];
            timer_div_log2   <= option_q[CSR_OP_OWNER] ? 8'h00
                                : {5'h00, option_q[2:0]} + 8'h01;
            wdt_div_log2     <= option_q[CSR_OP_OWNER] ? {5'h00, option_q[2:0]}
                                : 8'h00;
            irq_req <= irqctl_q[CSR_IC_ALL_EN] && (
                (|(irqctl_q[5:3] & irqctl_q[2:0]))
                || (irqctl_q[CSR_IC_PER_EN] && |(periph_flags & periph_enables)));
        end
    end

    // assertions
    property p_halt_clears;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && evt.halt && !evt.power_up && !evt.wdt_kick
            |=> !status_q[CSR_ST_HALT] && status_q[CSR_ST_WDX];
    endproperty
    a_halt_clears: assert property (p_halt_clears) else $error("halt flags wrong");

    property p_zero_flag;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && (alu.op == CSR_OP_ADD || alu.op == CSR_OP_SUB || alu.op == CSR_OP_LOG)
            |=> status_q[CSR_ST_Z] == ($past(alu.res) == 8'h00);
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

    property p_ro_bits;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && !evt.power_up && !evt.wdt_kick && !evt.halt && !evt.wdt_timeout
            |=> $stable(status_q[4:3]);
    endproperty
    a_ro_bits: assert property (p_ro_bits) else $error("read-only bits moved");

    property p_timer_flag;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && timer_zero_ovf |=> irqctl_q[CSR_IC_TIF];
    endproperty
    a_timer_flag: assert property (p_timer_flag) else $error("overflow flag lost");

    property p_global_gate;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && !irqctl_q[CSR_IC_ALL_EN] |=> !irq_req;
    endproperty
    a_global_gate: assert property (p_global_gate) else $error("request without global enable");

    property p_pc_copy;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && branch |=> pc_upper == $past(pclat_q);
    endproperty
    a_pc_copy: assert property (p_pc_copy) else $error("pc upper not loaded");

    property p_mismatch;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && pb_mismatch |=> irqctl_q[CSR_IC_PIF];
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("port flag not held");

    property p_tdiv;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && !option_q[CSR_OP_OWNER] ##1 clk_en
            |-> timer_div_log2 == {5'h00, $past(option_q[2:0])} + 8'h01;
    endproperty
    a_tdiv: assert property (p_tdiv) else $error("timer divide wrong");
endmodule : csr_core_regs

// >>> hw/csr_pkg.sv
// package: offsets, field positions, reset values and carriers of the core register bank
package csr_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [8:0] CSR_IDX_STATUS  = 9'h003;
    localparam logic [8:0] CSR_IDX_IRQCTL  = 9'h00b;
    localparam logic [8:0] CSR_IDX_OPTION  = 9'h081;
    localparam logic [8:0] CSR_IDX_PCLATCH = 9'h00a;
    localparam logic [8:0] CSR_IDX_RESCTL  = 9'h010;
    localparam logic [8:0] CSR_IDX_PORT_B  = 9'h006;
    localparam logic [6:0] CSR_BANK_MASK   = 7'h7f;
    // status fields
    localparam int CSR_ST_IBANK = 7;
    localparam int CSR_ST_DB_HI = 6;
    localparam int CSR_ST_DB_LO = 5;
    localparam int CSR_ST_WDX   = 4;
    localparam int CSR_ST_HALT  = 3;
    localparam int CSR_ST_Z     = 2;
    localparam int CSR_ST_NC    = 1;
    localparam int CSR_ST_C     = 0;
    // option fields
    localparam int CSR_OP_PUDIS = 7;
    localparam int CSR_OP_EDGE  = 6;
    localparam int CSR_OP_SRC   = 5;
    localparam int CSR_OP_TSE   = 4;
    localparam int CSR_OP_OWNER = 3;
    // irq control fields
    localparam int CSR_IC_ALL_EN = 7;
    localparam int CSR_IC_PER_EN = 6;
    localparam int CSR_IC_TIE  = 5;
    localparam int CSR_IC_EIE  = 4;
    localparam int CSR_IC_PIE  = 3;
    localparam int CSR_IC_TIF  = 2;
    localparam int CSR_IC_EIF  = 1;
    localparam int CSR_IC_PIF  = 0;
    // reset values
    localparam logic [7:0] CSR_RST_STATUS = 8'h18;
    localparam logic [7:0] CSR_RST_OPTION = 8'hff;
    localparam logic [7:0] CSR_RST_IRQCTL = 8'h00;
    localparam logic [4:0] CSR_RST_PCLAT  = 5'h00;
    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        CSR_OP_NONE = 3'h0,
        CSR_OP_ADD  = 3'h1,
        CSR_OP_SUB  = 3'h2,
        CSR_OP_LOG  = 3'h3,
        CSR_OP_RRC  = 3'h4,
        CSR_OP_RLC  = 3'h5
    } csr_alu_e;

    // core-side operation carrier
    typedef struct packed {
        csr_alu_e   op;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] res;
        logic       dest_status;
        logic [7:0] wdata;
    } csr_alu_s;

    typedef struct packed {
        logic wdt_kick;
        logic halt;
        logic wdt_timeout;
        logic power_up;
    } csr_evt_s;
endpackage : csr_pkg
